// ===== cfbu_core.sv
// Control-flow unit: calls, returns, compares, skips and flag branches.
// Assumes operands, I/O bit, stack value and next-word length come from
// neighbouring core logic on the same clock, valid beside instrValid.
`timescale 1ns/10ps
`default_nettype none
`include "cfbu_regs.svh"

module cfbu_core #(
  parameter int OFFSET_BITS = 12,
  parameter int PC_BITS = 22
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire cfbu_pkg::cfbu_op_e instrOp,
  input wire logic [7:0] rdVal,
  input wire logic [7:0] rrVal,
  input wire logic [7:0] immVal,
  input wire logic [2:0] bitSel,
  input wire logic [OFFSET_BITS-1:0] branchOffset,
  input wire logic ioBitVal,
  input wire logic nextIsLong,
  input wire logic pcWide,
  input wire logic [15:0] zPointer,
  input wire logic [21:0] stackPc,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic [21:0] pcOut,
  output logic [7:0] statusOut,
  output logic busy,
  output logic instrDone,
  output logic retPush,
  output logic [21:0] retAddr
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (OFFSET_BITS < 2 || OFFSET_BITS > 22)
  begin : gOffsetRange
    $error("cfbu_core: OFFSET_BITS must lie in 2..22");
  end
  if (PC_BITS != 22)
  begin : gPcWidth
    $error("cfbu_core: PC_BITS must be 22");
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  cfbu_pkg::cfbu_state_s s_q;
  cfbu_pkg::cfbu_state_s s_d;

  ////////////////////////////////////////////////////////////////////////
  // Compare arithmetic, shared by all three compares

  logic useCarryIn;
  logic [7:0] subB;
  logic [7:0] subRes;
  logic [8:0] subWide;
  logic flagH;
  logic flagV;
  logic flagC;
  logic flagN;
  logic flagZ;
  logic [7:0] cmpStatus;

  always_comb
  begin
    useCarryIn = (instrOp == cfbu_pkg::OP_COMPARE_WITH_CARRY_IN);
    subB = (instrOp == cfbu_pkg::OP_COMPARE_IMMEDIATE) ? immVal : rrVal;
    // Result is discarded; only flags are kept
    subWide = {1'b0, rdVal} - {1'b0, subB}
              - {8'h00, useCarryIn & s_q.status[`CFBU_FLAG_CARRY]};
    subRes = subWide[7:0];
    flagH = (~rdVal[3] & subB[3]) | (subB[3] & subRes[3]) | (subRes[3] & ~rdVal[3]);
    flagV = (rdVal[7] & ~subB[7] & ~subRes[7]) | (~rdVal[7] & subB[7] & subRes[7]);
    flagC = (~rdVal[7] & subB[7]) | (subB[7] & subRes[7]) | (subRes[7] & ~rdVal[7]);
    flagN = subRes[7];
    // With carry in, zero only survives if it was already set
    flagZ = (subRes == 8'h00) & (~useCarryIn | s_q.status[`CFBU_FLAG_ZERO]);
    cmpStatus = s_q.status;
    cmpStatus[`CFBU_FLAG_HALF] = flagH;
    cmpStatus[`CFBU_FLAG_OVF] = flagV;
    cmpStatus[`CFBU_FLAG_CARRY] = flagC;
    cmpStatus[`CFBU_FLAG_NEG] = flagN;
    cmpStatus[`CFBU_FLAG_ZERO] = flagZ;
    cmpStatus[`CFBU_FLAG_SIGN] = flagN ^ flagV;
  end

  ////////////////////////////////////////////////////////////////////////
  // Branch condition decode

  logic isBranch;
  logic branchTaken;
  logic [21:0] offsetExt;
  logic [21:0] branchTarget;
  logic [21:0] pcNext;
  logic [21:0] skipTarget;
  logic [7:0] st;

  always_comb
  begin
    st = s_q.status;
    isBranch = 1'b1;
    branchTaken = 1'b0;
    case (instrOp)
      cfbu_pkg::OP_BRANCH_STATUS_BIT_SET: branchTaken = st[bitSel];
      cfbu_pkg::OP_BRANCH_STATUS_BIT_CLEAR: branchTaken = ~st[bitSel];
      cfbu_pkg::OP_BRANCH_SIGNED_GE:
        branchTaken = ~(st[`CFBU_FLAG_NEG] ^ st[`CFBU_FLAG_OVF]);
      cfbu_pkg::OP_BRANCH_SIGNED_LT:
        branchTaken = st[`CFBU_FLAG_NEG] ^ st[`CFBU_FLAG_OVF];
      cfbu_pkg::OP_BRANCH_UNSIGNED_GE: branchTaken = ~st[`CFBU_FLAG_CARRY];
      cfbu_pkg::OP_BRANCH_UNSIGNED_LT: branchTaken = st[`CFBU_FLAG_CARRY];
      cfbu_pkg::OP_BRANCH_HALF_CARRY_SET: branchTaken = st[`CFBU_FLAG_HALF];
      cfbu_pkg::OP_BRANCH_HALF_CARRY_CLEAR: branchTaken = ~st[`CFBU_FLAG_HALF];
      cfbu_pkg::OP_BRANCH_OVERFLOW_SET: branchTaken = st[`CFBU_FLAG_OVF];
      cfbu_pkg::OP_BRANCH_OVERFLOW_CLEAR: branchTaken = ~st[`CFBU_FLAG_OVF];
      cfbu_pkg::OP_BRANCH_INTERRUPTS_ON: branchTaken = st[`CFBU_FLAG_IEN];
      cfbu_pkg::OP_BRANCH_INTERRUPTS_OFF: branchTaken = ~st[`CFBU_FLAG_IEN];
      cfbu_pkg::OP_BRANCH_TFLAG_SET: branchTaken = st[`CFBU_FLAG_TBIT];
      cfbu_pkg::OP_BRANCH_TFLAG_CLEAR: branchTaken = ~st[`CFBU_FLAG_TBIT];
      cfbu_pkg::OP_BRANCH_CARRY_SET: branchTaken = st[`CFBU_FLAG_CARRY];
      cfbu_pkg::OP_BRANCH_CARRY_CLEAR: branchTaken = ~st[`CFBU_FLAG_CARRY];
      cfbu_pkg::OP_BRANCH_IF_ZERO: branchTaken = st[`CFBU_FLAG_ZERO];
      cfbu_pkg::OP_BRANCH_IF_NONZERO: branchTaken = ~st[`CFBU_FLAG_ZERO];
      cfbu_pkg::OP_BRANCH_IF_NEGATIVE: branchTaken = st[`CFBU_FLAG_NEG];
      cfbu_pkg::OP_BRANCH_IF_POSITIVE: branchTaken = ~st[`CFBU_FLAG_NEG];
      default: isBranch = 1'b0;
    endcase
    // Offset is signed; sign-extend to the full counter width
    offsetExt = {{(22 - OFFSET_BITS){branchOffset[OFFSET_BITS-1]}}, branchOffset};
    pcNext = s_q.pc + 22'h000001;
    branchTarget = pcNext + offsetExt;
    // Skipping a two-word instruction jumps one word further
    skipTarget = s_q.pc + (nextIsLong ? 22'h000003 : 22'h000002);
  end

  ////////////////////////////////////////////////////////////////////////
  // Skip condition decode

  logic isSkip;
  logic skipTaken;
  logic ioSkip;

  always_comb
  begin
    isSkip = 1'b1;
    skipTaken = 1'b0;
    ioSkip = 1'b0;
    case (instrOp)
      cfbu_pkg::OP_COMPARE_SKIP_EQUAL: skipTaken = (rdVal == rrVal);
      cfbu_pkg::OP_REG_BIT_CLEAR_SKIP: skipTaken = ~rrVal[bitSel];
      cfbu_pkg::OP_REG_BIT_SET_SKIP: skipTaken = rrVal[bitSel];
      cfbu_pkg::OP_IO_BIT_CLEAR_SKIP:
      begin
        skipTaken = ~ioBitVal;
        ioSkip = 1'b1;
      end
      cfbu_pkg::OP_IO_BIT_SET_SKIP:
      begin
        skipTaken = ioBitVal;
        ioSkip = 1'b1;
      end
      default: isSkip = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-instruction target and cycle count

  logic [21:0] target;
  logic [2:0] cycles;
  logic isCall;
  logic isCompare;
  logic isIntExit;

  always_comb
  begin
    target = pcNext;
    cycles = `CFBU_CYC_ONE;
    isCall = 1'b0;
    isCompare = 1'b0;
    isIntExit = 1'b0;
    case (instrOp)
      cfbu_pkg::OP_INDIRECT_CALL:
      begin
        target = {6'h00, zPointer};
        cycles = pcWide ? `CFBU_CYC_PTRCALL_WIDE : `CFBU_CYC_PTRCALL_NARROW;
        isCall = 1'b1;
      end
      cfbu_pkg::OP_EXTENDED_INDIRECT_CALL:
      begin
        target = {s_q.farBits, zPointer};
        cycles = `CFBU_CYC_FARCALL;
        isCall = 1'b1;
      end
      cfbu_pkg::OP_SUBROUTINE_EXIT,
      cfbu_pkg::OP_INTERRUPT_EXIT:
      begin
        target = stackPc;
        cycles = pcWide ? `CFBU_CYC_RET_WIDE : `CFBU_CYC_RET_NARROW;
        isIntExit = (instrOp == cfbu_pkg::OP_INTERRUPT_EXIT);
      end
      cfbu_pkg::OP_COMPARE_REGISTERS,
      cfbu_pkg::OP_COMPARE_WITH_CARRY_IN,
      cfbu_pkg::OP_COMPARE_IMMEDIATE:
      begin
        isCompare = 1'b1;
        cycles = `CFBU_CYC_ONE;
      end
      default:
      begin
        if (isBranch && branchTaken)
        begin
          target = branchTarget;
          cycles = `CFBU_CYC_BRANCH_TAKEN;
        end
        else if (isSkip && skipTaken)
        begin
          target = skipTarget;
          // One extra cycle per skipped word, one more for the I/O read
          cycles = (nextIsLong ? 3'h3 : 3'h2) + {2'b00, ioSkip};
        end
        else if (isSkip)
        begin
          cycles = `CFBU_CYC_ONE + {2'b00, ioSkip};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic accept;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.push = 1'b0;
    accept = instrValid && (s_q.fsm == cfbu_pkg::ST_IDLE) && (instrOp != cfbu_pkg::OP_NONE);

    // Software writes first, so hardware updates below take precedence
    if (regWrite)
    begin
      case (regAddr)
        `CFBU_REG_STATUS: s_d.status = regWdata;
        `CFBU_REG_FARCALL: s_d.farBits = regWdata[5:0];
        default: s_d.status = s_d.status;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    s_d.rdData = 8'h00;
    if (regRead)
    begin
      case (regAddr)
        `CFBU_REG_STATUS: s_d.rdData = s_q.status;
        `CFBU_REG_FARCALL: s_d.rdData = {2'b00, s_q.farBits};
        `CFBU_REG_PCLOW: s_d.rdData = s_q.pc[7:0];
        `CFBU_REG_PCMID: s_d.rdData = s_q.pc[15:8];
        `CFBU_REG_PCHIGH: s_d.rdData = {2'b00, s_q.pc[21:16]};
        `CFBU_REG_INFO: s_d.rdData = {4'h0, s_q.cnt, s_q.busy};
        default: s_d.rdData = 8'h00;
      endcase
    end

    case (s_q.fsm)
      cfbu_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          if (isCompare)
          begin
            s_d.status = cmpStatus;
          end
          if (isCall)
          begin
            // Return address handed to the stack logic at once
            s_d.push = 1'b1;
            s_d.retAddr = pcNext;
          end
          if (cycles == `CFBU_CYC_ONE)
          begin
            s_d.pc = target;
            s_d.done = 1'b1;
          end
          else
          begin
            s_d.fsm = cfbu_pkg::ST_EXEC;
            s_d.pcTarget = target;
            s_d.cnt = cycles - 3'h1;
            s_d.busy = 1'b1;
            s_d.setIenAtEnd = isIntExit;
          end
        end
      end
      cfbu_pkg::ST_EXEC:
      begin
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1)
        begin
          s_d.fsm = cfbu_pkg::ST_IDLE;
          s_d.pc = s_q.pcTarget;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          if (s_q.setIenAtEnd)
          begin
            s_d.status[`CFBU_FLAG_IEN] = 1'b1;
          end
          s_d.setIenAtEnd = 1'b0;
        end
      end
      default:
      begin
        s_d.fsm = cfbu_pkg::ST_IDLE;
        s_d.busy = 1'b0;
        s_d.cnt = 3'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q.fsm <= cfbu_pkg::ST_IDLE;
      s_q.pc <= `CFBU_PC_RESET;
      s_q.pcTarget <= `CFBU_PC_RESET;
      s_q.status <= `CFBU_STATUS_RESET;
      s_q.setIenAtEnd <= 1'b0;
      s_q.farBits <= `CFBU_FARCALL_RESET;
      s_q.cnt <= 3'h0;
      s_q.busy <= 1'b0;
      s_q.done <= 1'b0;
      s_q.push <= 1'b0;
      s_q.retAddr <= `CFBU_PC_RESET;
      s_q.rdData <= 8'h00;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state flops

  assign regRdata = s_q.rdData;
  assign pcOut = s_q.pc;
  assign statusOut = s_q.status;
  assign busy = s_q.busy;
  assign instrDone = s_q.done;
  assign retPush = s_q.push;
  assign retAddr = s_q.retAddr;

endmodule

`default_nettype wire

// ===== cfbu_core_chk.sv
// Timing and value checks on the branch unit ports.
// Assumes bind to cfbu_core; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module cfbu_core_chk #(
  parameter int OFFSET_BITS = 12,
  parameter int PC_BITS = 22
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire cfbu_pkg::cfbu_op_e instrOp,
  input wire logic [7:0] rdVal,
  input wire logic [7:0] rrVal,
  input wire logic [2:0] bitSel,
  input wire logic [OFFSET_BITS-1:0] branchOffset,
  input wire logic nextIsLong,
  input wire logic pcWide,
  input wire logic [15:0] zPointer,
  input wire logic [21:0] stackPc,
  input wire logic [21:0] pcOut,
  input wire logic [7:0] statusOut,
  input wire logic busy,
  input wire logic instrDone,
  input wire logic retPush,
  input wire logic [21:0] retAddr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic acc = instrValid && !busy;
  ////////////////////////////////////////////////////////////////
  taken_branch_a: assert property (acc && instrOp == cfbu_pkg::OP_BRANCH_STATUS_BIT_SET
    && statusOut[bitSel] |=> busy ##1 instrDone
    && pcOut == $past(pcOut, 2) + 22'h1 + 22'($signed($past(branchOffset, 2))))
    else $error("taken branch target or timing wrong");
  not_taken_a: assert property (acc && instrOp == cfbu_pkg::OP_BRANCH_STATUS_BIT_CLEAR
    && statusOut[bitSel] |=> instrDone && pcOut == $past(pcOut) + 22'h1)
    else $error("untaken branch wrong");
  compare_one_a: assert property (acc && instrOp == cfbu_pkg::OP_COMPARE_IMMEDIATE
    |=> instrDone && !busy && pcOut == $past(pcOut) + 22'h1)
    else $error("compare not one cycle");
  compare_flags_a: assert property (acc && instrOp == cfbu_pkg::OP_COMPARE_REGISTERS
    |=> statusOut[1] == ($past(rdVal) == $past(rrVal))
    && statusOut[0] == ($past(rdVal) < $past(rrVal)))
    else $error("compare zero or carry wrong");
  skip_unequal_a: assert property (acc && instrOp == cfbu_pkg::OP_COMPARE_SKIP_EQUAL
    && rdVal != rrVal |=> instrDone && $stable(statusOut))
    else $error("unequal skip wrong");
  skip_long_a: assert property (acc && instrOp == cfbu_pkg::OP_REG_BIT_SET_SKIP
    && rrVal[bitSel] && nextIsLong |-> ##3 instrDone && pcOut == $past(pcOut, 3) + 22'h3)
    else $error("long skip wrong");
  ptr_call_a: assert property (acc && instrOp == cfbu_pkg::OP_INDIRECT_CALL && !pcWide
    |=> retPush && retAddr == $past(pcOut) + 22'h1
    ##1 instrDone && pcOut == {6'h00, $past(zPointer, 2)})
    else $error("indirect call wrong");
  far_call_a: assert property (acc && instrOp == cfbu_pkg::OP_EXTENDED_INDIRECT_CALL
    |=> busy ##1 busy ##1 instrDone && pcOut[15:0] == $past(zPointer, 3))
    else $error("extended call wrong");
  int_exit_a: assert property (acc && instrOp == cfbu_pkg::OP_INTERRUPT_EXIT && pcWide
    |-> ##5 instrDone && statusOut[7] && pcOut == $past(stackPc, 5))
    else $error("interrupt exit wrong");
  busy_bound_a: assert property (busy [*4] |=> !busy)
    else $error("busy too long");
  cover property (acc && instrOp == cfbu_pkg::OP_INTERRUPT_EXIT);
  cover property (retPush);
  cover property (busy ##1 instrDone);
endmodule
`default_nettype wire

// ===== cfbu_pkg.sv
// Types shared by the branch unit.
// Assumes nothing beyond the constants header.
`default_nettype none
package cfbu_pkg;

  typedef enum logic [5:0] {
    OP_NONE,
    OP_INDIRECT_CALL,
    OP_EXTENDED_INDIRECT_CALL,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT,
    OP_COMPARE_SKIP_EQUAL,
    OP_COMPARE_REGISTERS,
    OP_COMPARE_WITH_CARRY_IN,
    OP_COMPARE_IMMEDIATE,
    OP_REG_BIT_CLEAR_SKIP,
    OP_REG_BIT_SET_SKIP,
    OP_IO_BIT_CLEAR_SKIP,
    OP_IO_BIT_SET_SKIP,
    OP_BRANCH_STATUS_BIT_SET,
    OP_BRANCH_STATUS_BIT_CLEAR,
    OP_BRANCH_IF_ZERO,
    OP_BRANCH_IF_NONZERO,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_UNSIGNED_GE,
    OP_BRANCH_UNSIGNED_LT,
    OP_BRANCH_IF_NEGATIVE,
    OP_BRANCH_IF_POSITIVE,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALF_CARRY_SET,
    OP_BRANCH_HALF_CARRY_CLEAR,
    OP_BRANCH_TFLAG_SET,
    OP_BRANCH_TFLAG_CLEAR,
    OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_INTERRUPTS_ON,
    OP_BRANCH_INTERRUPTS_OFF
  } cfbu_op_e;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } cfbu_fsm_e;

  typedef struct packed {
    cfbu_fsm_e fsm;
    logic [21:0] pc;
    logic [21:0] pcTarget;
    logic [7:0] status;
    logic setIenAtEnd;
    logic [5:0] farBits;
    logic [2:0] cnt;
    logic busy;
    logic done;
    logic push;
    logic [21:0] retAddr;
    logic [7:0] rdData;
  } cfbu_state_s;

endpackage

`default_nettype wire

// ===== cfbu_regs.svh
// Offsets, field positions, reset values and cycle counts of the branch unit.
// Assumes a plain register port with 4-bit address and 8-bit data.
`ifndef CFBU_REGS_SVH
`define CFBU_REGS_SVH

`define CFBU_REG_STATUS 4'h0
`define CFBU_REG_FARCALL 4'h1
`define CFBU_REG_PCLOW 4'h2
`define CFBU_REG_PCMID 4'h3
`define CFBU_REG_PCHIGH 4'h4
`define CFBU_REG_INFO 4'h5

`define CFBU_FLAG_CARRY 3'h0
`define CFBU_FLAG_ZERO 3'h1
`define CFBU_FLAG_NEG 3'h2
`define CFBU_FLAG_OVF 3'h3
`define CFBU_FLAG_SIGN 3'h4
`define CFBU_FLAG_HALF 3'h5
`define CFBU_FLAG_TBIT 3'h6
`define CFBU_FLAG_IEN 3'h7

`define CFBU_STATUS_RESET 8'h00
`define CFBU_FARCALL_RESET 6'h00
`define CFBU_PC_RESET 22'h000000

`define CFBU_CYC_BRANCH_TAKEN 3'h2
`define CFBU_CYC_PTRCALL_NARROW 3'h2
`define CFBU_CYC_PTRCALL_WIDE 3'h3
`define CFBU_CYC_FARCALL 3'h3
`define CFBU_CYC_RET_NARROW 3'h4
`define CFBU_CYC_RET_WIDE 3'h5
`define CFBU_CYC_ONE 3'h1

`endif

// ===== cfbu_stack_model.sv
// One-deep return stack beside the branch unit.
// Assumes returns never pop: the last pushed address stays visible.
`timescale 1ns/10ps
`default_nettype none
module cfbu_stack_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic retPush,
  input wire logic [21:0] retAddr,
  output logic [21:0] stackPc
);
  // Empty stack shows a marker pattern, never a plausible address
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      stackPc <= 22'h2AAAAA;
    else if (retPush)
      stackPc <= retAddr;
    else
      stackPc <= stackPc;
  end
endmodule
`default_nettype wire

// ===== control_flow_branch_unit_tb.sv
// Directed bench for the branch unit and its register port.
// Assumes cfbu_core, the stack model and the checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module control_flow_branch_unit_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  cfbu_pkg::cfbu_op_e instrOp = cfbu_pkg::OP_NONE;
  logic [7:0] rdVal = 8'h00;
  logic [7:0] rrVal = 8'h00;
  logic [7:0] immVal = 8'h00;
  logic [2:0] bitSel = 3'h0;
  logic [11:0] branchOffset = 12'hFFD;
  logic ioBitVal = 1'b0;
  logic nextIsLong = 1'b0;
  logic pcWide = 1'b0;
  logic [15:0] zPointer = 16'h5A3C;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata, statusOut;
  logic [21:0] pcOut, retAddr, stackPc;
  logic busy, instrDone, retPush;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [21:0] epc = 22'h000000;
  logic [21:0] r;
  logic [7:0] sv [3] = '{8'h00, 8'hFF, 8'h08};
  logic [3:0] bsel [10] = '{4'h4, 4'h1, 4'h0, 4'h0, 4'h2, 4'h8, 4'h5, 4'h6, 4'h3, 4'h7};
  logic f, t;
  int p;
  always #5 sys_clk = ~sys_clk;
  cfbu_core #(.OFFSET_BITS(12), .PC_BITS(22)) uut (.sys_clk(sys_clk), .rst(rst),
    .instrValid(instrValid), .instrOp(instrOp), .rdVal(rdVal), .rrVal(rrVal),
    .immVal(immVal), .bitSel(bitSel), .branchOffset(branchOffset), .ioBitVal(ioBitVal),
    .nextIsLong(nextIsLong), .pcWide(pcWide), .zPointer(zPointer), .stackPc(stackPc),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pcOut(pcOut), .statusOut(statusOut), .busy(busy),
    .instrDone(instrDone), .retPush(retPush), .retAddr(retAddr));
  cfbu_stack_model stack (.sys_clk(sys_clk), .rst(rst), .retPush(retPush),
    .retAddr(retAddr), .stackPc(stackPc));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    check(32'(regRdata), 32'(e));
  endtask
  // Cycle count and new pc; m is {pcWide, nextIsLong, ioBitVal}
  task automatic ex(input cfbu_pkg::cfbu_op_e op, input logic [7:0] a, input logic [7:0] b,
      input logic [2:0] s, input logic [2:0] m, input int n, input logic [21:0] pc);
    int k;
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrOp <= op;
    rdVal <= a;
    rrVal <= b;
    immVal <= b;
    bitSel <= s;
    {pcWide, nextIsLong, ioBitVal} <= m;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    k = 1;
    #1;
    while (instrDone !== 1'b1 && k < 8)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(32'(k), 32'(n));
    check(32'(pcOut), 32'(pc));
    epc = pc;
  endtask
  // Hang guard; whole run is well under this
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h9, 8'h00);
    rd(4'h5, 8'h00);
    check(32'(pcOut), 32'h0);
    $display("test reset done");
    foreach (sv[j])
      for (int i = 13; i <= 32; i++)
      begin
        wr(4'h0, sv[j]);
        p = (i - 13) / 2;
        f = (bsel[p] == 4'h8) ? (sv[j][2] ^ sv[j][3]) : sv[j][bsel[p][2:0]];
        t = f ^ ((i - 13) % 2 == 1) ^ (p == 3 || p == 5);
        ex(cfbu_pkg::cfbu_op_e'(6'(i)), 8'h00, 8'h00, 3'h4, 3'h0, t ? 2 : 1,
          t ? epc + 22'h3FFFFE : epc + 22'h1);
        check(32'(statusOut), 32'(sv[j]));
      end
    $display("test branches done");
    wr(4'h0, 8'hA5);
    for (int l = 0; l < 2; l++)
    begin
      ex(cfbu_pkg::OP_COMPARE_SKIP_EQUAL, 8'h3C, 8'h3C, 3'h0, {1'b0, l[0], 1'b0}, 2 + l,
        epc + 22'(2 + l));
      ex(cfbu_pkg::OP_COMPARE_SKIP_EQUAL, 8'h3C, 8'h3D, 3'h0, 3'h2, 1, epc + 22'h1);
      ex(cfbu_pkg::OP_REG_BIT_CLEAR_SKIP, 8'h00, 8'hDF, 3'h5, {1'b0, l[0], 1'b0}, 2 + l,
        epc + 22'(2 + l));
      ex(cfbu_pkg::OP_REG_BIT_SET_SKIP, 8'h00, 8'h20, 3'h5, {1'b0, l[0], 1'b0}, 2 + l,
        epc + 22'(2 + l));
      ex(cfbu_pkg::OP_REG_BIT_SET_SKIP, 8'h00, 8'hDF, 3'h5, 3'h0, 1, epc + 22'h1);
      ex(cfbu_pkg::OP_IO_BIT_CLEAR_SKIP, 8'h00, 8'h00, 3'h0, {1'b0, l[0], 1'b0}, 3 + l,
        epc + 22'(2 + l));
      ex(cfbu_pkg::OP_IO_BIT_CLEAR_SKIP, 8'h00, 8'h00, 3'h0, 3'h1, 2, epc + 22'h1);
      ex(cfbu_pkg::OP_IO_BIT_SET_SKIP, 8'h00, 8'h00, 3'h0, {1'b0, l[0], 1'b1}, 3 + l,
        epc + 22'(2 + l));
      ex(cfbu_pkg::OP_IO_BIT_SET_SKIP, 8'h00, 8'h00, 3'h0, 3'h0, 2, epc + 22'h1);
    end
    check(32'(statusOut), 32'hA5);
    $display("test skips done");
    wr(4'h0, 8'h00);
    ex(cfbu_pkg::OP_COMPARE_REGISTERS, 8'h10, 8'h20, 3'h0, 3'h0, 1, epc + 22'h1);
    check(32'(statusOut), 32'h15);
    ex(cfbu_pkg::OP_COMPARE_WITH_CARRY_IN, 8'h10, 8'h0F, 3'h0, 3'h0, 1, epc + 22'h1);
    check(32'(statusOut), 32'h20);
    ex(cfbu_pkg::OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 3'h0, 3'h0, 1, epc + 22'h1);
    check(32'(statusOut), 32'h38);
    $display("test compares done");
    wr(4'h1, 8'hEA);
    rd(4'h1, 8'h2A);
    r = epc + 22'h1;
    ex(cfbu_pkg::OP_INDIRECT_CALL, 8'h00, 8'h00, 3'h0, 3'h0, 2, 22'h005A3C);
    check(32'(retAddr), 32'(r));
    ex(cfbu_pkg::OP_INDIRECT_CALL, 8'h00, 8'h00, 3'h0, 3'h4, 3, 22'h005A3C);
    ex(cfbu_pkg::OP_EXTENDED_INDIRECT_CALL, 8'h00, 8'h00, 3'h0, 3'h0, 3, 22'h2A5A3C);
    ex(cfbu_pkg::OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 3'h0, 3'h0, 4, 22'h005A3D);
    wr(4'h0, 8'h00);
    ex(cfbu_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00, 3'h0, 3'h4, 5, 22'h005A3D);
    check(32'(statusOut), 32'h80);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h3D);
    rd(4'h3, 8'h5A);
    rd(4'h4, 8'h00);
    $display("test calls done");
    print_verdict();
  end
endmodule
bind cfbu_core cfbu_core_chk #(.OFFSET_BITS(OFFSET_BITS), .PC_BITS(PC_BITS)) chk (
  .sys_clk(sys_clk), .rst(rst), .instrValid(instrValid), .instrOp(instrOp), .rdVal(rdVal),
  .rrVal(rrVal), .bitSel(bitSel), .branchOffset(branchOffset), .nextIsLong(nextIsLong),
  .pcWide(pcWide), .zPointer(zPointer), .stackPc(stackPc), .pcOut(pcOut),
  .statusOut(statusOut), .busy(busy), .instrDone(instrDone), .retPush(retPush),
  .retAddr(retAddr));
`default_nettype wire
